// [rtl/ebs_defs.svh]
// constants for the external brake sequencer
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH
`define EBS_CTRL_ACTIVE     2'h1
`define EBS_WAIT_MAX_MS     16'h1388
`define EBS_CLK_HZ          50000000
`define EBS_MS_CYCLES       ((`EBS_CLK_HZ) / 1000)
`define EBS_FAULT_NONE      8'h00
`define EBS_FAULT_START     8'h20
`define EBS_FAULT_STOP      8'h24
`define EBS_FREQ_ZERO       16'h0000
`endif

// [rtl/ebs_pkg.sv]
// types for the external brake sequencer
package ebs_pkg;
  typedef enum logic [3:0] {
    EBS_IDLE      = 4'h0,
    EBS_RAMP_UP   = 4'h1,
    EBS_REL_WAIT  = 4'h2,
    EBS_CONF_WAIT = 4'h3,
    EBS_ACC_WAIT  = 4'h4,
    EBS_RUN       = 4'h5,
    EBS_RAMP_DN   = 4'h6,
    EBS_ENG_WAIT  = 4'h7,
    EBS_STOP_WAIT = 4'h8,
    EBS_TO_ZERO   = 4'h9,
    EBS_FAULT     = 4'hA
  } ebs_state_t;

  // wait times in milliseconds, each 0 to 5000
  typedef struct packed {
    logic [15:0] release_wait_time;
    logic [15:0] accel_wait_time;
    logic [15:0] stop_wait_time;
    logic [15:0] confirm_wait_time;
  } ebs_times_t;

  typedef struct packed {
    logic       cmd_start;
    logic       cmd_stop;
    logic       at_target;
    logic       current_ok;
  } ebs_drive_in_t;

  typedef struct packed {
    logic [15:0] freq_target;
    logic        ramp_enable;
  } ebs_drive_out_t;
endpackage

// [rtl/ebs_timer.sv]
// millisecond wait timer for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ebs_defs.svh"
module ebs_timer #(
  parameter int unsigned MS_CYCLES = `EBS_MS_CYCLES
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // control
  input  wire logic        load_in,
  input  wire logic [15:0] ms_in,
  output logic             done_out
);
  typedef struct packed {
    logic [31:0] tick;
    logic [15:0] ms_left;
    logic        run;
  } ebs_tmr_state_t;

  ebs_tmr_state_t s_q, s_d;

  function automatic logic [15:0] ebs_clamp(input logic [15:0] v);
    return (v > `EBS_WAIT_MAX_MS) ? 16'(`EBS_WAIT_MAX_MS) : v;
  endfunction

  always_comb begin
    s_d = s_q;
    if (load_in) begin
      s_d.ms_left = ebs_clamp(ms_in);
      s_d.tick    = 32'h0;
      s_d.run     = 1'b1;
    end else if (s_q.run) begin
      if (s_q.ms_left == 16'h0) begin
        s_d.run = 1'b0;
      end else if (s_q.tick == 32'(MS_CYCLES - 1)) begin
        s_d.tick    = 32'h0;
        s_d.ms_left = s_q.ms_left - 16'h1;
      end else begin
        s_d.tick = s_q.tick + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // done for one cycle after expiry; kept off load_in, since the
  // caller loads on done and would otherwise close a loop
  assign done_out = s_q.run && (s_q.ms_left == 16'h0);
endmodule
`default_nettype wire

// [rtl/ebs_sequencer.sv]
// external brake sequencer: start and stop brake handling
`timescale 1ns/1ps
`default_nettype none
`include "ebs_defs.svh"
// Notes on behaviour
// - sequence runs only when brake control enable equals 01
// - on start, ramp to brake enable frequency and hold there
// - at that frequency, start release wait timer
// - timer expired and current reached: assert brake release output
// - timer expired without current: assert brake fault instead
// - release asserted starts confirm wait timer
// - confirm before timeout starts acceleration wait timer
// - after acceleration wait, ramp to setpoint frequency
// - no confirm by timeout: drop release, fault, code E32
// - stop: ramp to brake frequency, drop release, start confirm timer
// - confirm still high at timeout: fault, code E36
// - confirm dropped: wait stop time, then ramp to 0 Hz
// - all four wait times programmable from 0 to 5 s
module ebs_sequencer #(
  parameter int unsigned MS_CYCLES = `EBS_MS_CYCLES
) (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_b_in,
  // configuration
  input  wire logic [1:0]              brake_control_enable_in,
  input  wire ebs_pkg::ebs_times_t     times_in,
  input  wire logic [15:0]             brake_enable_frequency_in,
  input  wire logic [15:0]             setpoint_frequency_in,
  // drive interface
  input  wire ebs_pkg::ebs_drive_in_t  drive_in,
  output ebs_pkg::ebs_drive_out_t      drive_out,
  // brake pins and fault
  input  wire logic                    brake_confirm_input_in,
  input  wire logic                    fault_clear_in,
  output logic                         brake_release_output_out,
  output logic                         brake_fault_output_out,
  output logic [7:0]                   fault_code_out,
  output logic [3:0]                   state_out
);
  import ebs_pkg::*;

  typedef struct packed {
    ebs_state_t  st;
    logic [1:0]  conf_sync;
    logic        release_o;
    logic        fault_o;
    logic [7:0]  code;
    logic [15:0] freq;
    logic        ramp;
  } ebs_seq_state_t;

  ebs_seq_state_t s_q, s_d;
  logic           tmr_load;
  logic [15:0]    tmr_ms;
  logic           tmr_done;
  logic           active;
  logic           confirm;

  ebs_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .load_in  (tmr_load),
    .ms_in    (tmr_ms),
    .done_out (tmr_done)
  );

  assign active  = (brake_control_enable_in == `EBS_CTRL_ACTIVE);
  // confirm pin is asynchronous, read only after two flops
  assign confirm = s_q.conf_sync[1];

  always_comb begin
    s_d           = s_q;
    s_d.conf_sync = {s_q.conf_sync[0], brake_confirm_input_in};
    tmr_load      = 1'b0;
    tmr_ms        = 16'h0;
    unique case (s_q.st)
      EBS_IDLE: begin
        s_d.release_o = 1'b0;
        s_d.freq      = `EBS_FREQ_ZERO;
        s_d.ramp      = 1'b0;
        if (active && drive_in.cmd_start) begin
          s_d.freq = brake_enable_frequency_in;
          s_d.ramp = 1'b1;
          s_d.st   = EBS_RAMP_UP;
        end
      end
      EBS_RAMP_UP: begin
        if (drive_in.at_target) begin
          tmr_load = 1'b1;
          tmr_ms   = times_in.release_wait_time;
          s_d.st   = EBS_REL_WAIT;
        end
      end
      EBS_REL_WAIT: begin
        if (tmr_done) begin
          if (drive_in.current_ok) begin
            s_d.release_o = 1'b1;
            tmr_load = 1'b1;
            tmr_ms   = times_in.confirm_wait_time;
            s_d.st   = EBS_CONF_WAIT;
          end else begin
            s_d.fault_o = 1'b1;
            s_d.st      = EBS_FAULT;
          end
        end
      end
      EBS_CONF_WAIT: begin
        if (confirm) begin
          tmr_load = 1'b1;
          tmr_ms   = times_in.accel_wait_time;
          s_d.st   = EBS_ACC_WAIT;
        end else if (tmr_done) begin
          s_d.release_o = 1'b0;
          s_d.fault_o   = 1'b1;
          s_d.code      = `EBS_FAULT_START;
          s_d.st        = EBS_FAULT;
        end
      end
      EBS_ACC_WAIT: begin
        if (tmr_done) begin
          s_d.freq = setpoint_frequency_in;
          s_d.st   = EBS_RUN;
        end
      end
      EBS_RUN: begin
        s_d.freq = setpoint_frequency_in;
        // stop ramps down to brake frequency
        if (drive_in.cmd_stop) begin
          s_d.freq = brake_enable_frequency_in;
          s_d.st   = EBS_RAMP_DN;
        end
      end
      EBS_RAMP_DN: begin
        if (drive_in.at_target) begin
          s_d.release_o = 1'b0;
          tmr_load      = 1'b1;
          tmr_ms        = times_in.confirm_wait_time;
          s_d.st        = EBS_ENG_WAIT;
        end
      end
      EBS_ENG_WAIT: begin
        if (!confirm) begin
          tmr_load = 1'b1;
          tmr_ms   = times_in.stop_wait_time;
          s_d.st   = EBS_STOP_WAIT;
        end else if (tmr_done) begin
          s_d.fault_o = 1'b1;
          s_d.code    = `EBS_FAULT_STOP;
          s_d.st      = EBS_FAULT;
        end
      end
      EBS_STOP_WAIT: begin
        if (tmr_done) begin
          s_d.freq = `EBS_FREQ_ZERO;
          s_d.st   = EBS_TO_ZERO;
        end
      end
      EBS_TO_ZERO: begin
        if (drive_in.at_target) begin
          s_d.ramp = 1'b0;
          s_d.st   = EBS_IDLE;
        end
      end
      EBS_FAULT: begin
        s_d.release_o = 1'b0;
        s_d.ramp      = 1'b0;
        s_d.freq      = `EBS_FREQ_ZERO;
        if (fault_clear_in) begin
          s_d.fault_o = 1'b0;
          s_d.code    = `EBS_FAULT_NONE;
          s_d.st      = EBS_IDLE;
        end
      end
      default: begin
        s_d.st = EBS_IDLE;
      end
    endcase
    if (!active && s_q.st != EBS_FAULT) begin
      s_d.st        = EBS_IDLE;
      s_d.release_o = 1'b0;
      s_d.freq      = `EBS_FREQ_ZERO;
      s_d.ramp      = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s_q <= '{st: EBS_IDLE, code: `EBS_FAULT_NONE,
               freq: `EBS_FREQ_ZERO, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign brake_release_output_out = s_q.release_o;
  assign brake_fault_output_out   = s_q.fault_o;
  assign fault_code_out           = s_q.code;
  assign state_out                = s_q.st;
  assign drive_out                = '{freq_target: s_q.freq,
                                      ramp_enable: s_q.ramp};
endmodule
`default_nettype wire

// [testbench/ebs_sequencer_monitor.sv]
// port assertions for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module ebs_sequencer_chk (
  input wire logic                   clock_in,
  input wire logic                   rst_b_in,
  input wire logic [1:0]             brake_control_enable_in,
  input wire logic [15:0]            brake_enable_frequency_in,
  input wire logic [15:0]            setpoint_frequency_in,
  input wire ebs_pkg::ebs_drive_in_t drive_in,
  input wire ebs_pkg::ebs_drive_out_t drive_out,
  input wire logic                   fault_clear_in,
  input wire logic                   brake_release_output_out,
  input wire logic                   brake_fault_output_out,
  input wire logic [7:0]             fault_code_out,
  input wire logic [3:0]             state_out
);
  import ebs_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_enable_gate: assert property (
    brake_control_enable_in != 2'h1 |=> !brake_release_output_out)
    else $error("release driven while disabled");
  a_start_ramp: assert property (
    state_out == EBS_IDLE && drive_in.cmd_start &&
    brake_control_enable_in == 2'h1 |=> state_out == EBS_RAMP_UP &&
    drive_out.freq_target == brake_enable_frequency_in && drive_out.ramp_enable)
    else $error("start did not ramp to brake frequency");
  a_current_fault: assert property (
    $rose(brake_fault_output_out) && $past(state_out) == EBS_REL_WAIT |->
    !brake_release_output_out && fault_code_out == 8'h00)
    else $error("current fault wrong");
  a_run_setpoint: assert property (
    state_out == EBS_RUN |-> brake_release_output_out &&
    drive_out.freq_target == setpoint_frequency_in)
    else $error("run without setpoint or release");
  a_start_timeout: assert property (
    $rose(brake_fault_output_out) && $past(state_out) == EBS_CONF_WAIT |->
    !brake_release_output_out && fault_code_out == 8'h20)
    else $error("start timeout fault wrong");
  a_engage_hold: assert property (
    state_out == EBS_ENG_WAIT |-> !brake_release_output_out &&
    drive_out.freq_target == brake_enable_frequency_in)
    else $error("engage wait wrong");
  a_stop_timeout: assert property (
    $rose(brake_fault_output_out) && $past(state_out) == EBS_ENG_WAIT |->
    fault_code_out == 8'h24)
    else $error("stop timeout code wrong");
  a_fault_hold: assert property (
    state_out == EBS_FAULT && !fault_clear_in && !drive_in.cmd_stop &&
    brake_control_enable_in == 2'h1 |=> state_out == EBS_FAULT &&
    brake_fault_output_out)
    else $error("fault left without clear");
  c_run: cover property (state_out == EBS_RUN);
  c_zero: cover property (state_out == EBS_TO_ZERO);
  c_e36: cover property ($rose(brake_fault_output_out) && fault_code_out == 8'h24);
endmodule
bind ebs_sequencer ebs_sequencer_chk u_chk (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .drive_in(drive_in),
  .brake_control_enable_in(brake_control_enable_in),
  .brake_enable_frequency_in(brake_enable_frequency_in),
  .setpoint_frequency_in(setpoint_frequency_in), .drive_out(drive_out),
  .fault_clear_in(fault_clear_in), .state_out(state_out),
  .brake_release_output_out(brake_release_output_out),
  .brake_fault_output_out(brake_fault_output_out),
  .fault_code_out(fault_code_out)
);
`default_nettype wire

// [testbench/ebs_brake_model.sv]
// external brake with release confirm contact
`timescale 1ns/1ps
`default_nettype none
module ebs_brake_model (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       release_in,
  // 0 healthy, 1 never frees, 2 sticks released
  input  wire logic [1:0] mode_in,
  output logic            confirm_out
);
  logic [2:0] lag_q;
  always @(posedge clock_in) begin
    lag_q <= rst_b_in ? {lag_q[1:0], release_in} : 3'h0;
    if (!rst_b_in || mode_in == 2'h1)
      confirm_out <= 1'b0;
    else
      confirm_out <= lag_q[2] | (mode_in == 2'h2 && confirm_out);
  end
endmodule
`default_nettype wire

// [testbench/ebs_sequencer_test.sv]
// self-checking bench for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module ebs_sequencer_test;
  import ebs_pkg::*;
  typedef struct packed {
    logic cur; logic [1:0] mode; logic [3:0] st; logic [9:0] outs;
  } ebs_row_t;
  localparam logic [15:0] FB = 16'h0123;
  localparam logic [15:0] FS = 16'h0ABC;
  logic clk = 1'b0, rst_b = 1'b0, st = 1'b0, sp = 1'b0;
  logic at = 1'b0, cur = 1'b0, clr = 1'b0, conf, rel, flt;
  logic [1:0] en = 2'h1, mode = 2'h0;
  logic [15:0] tgt_q = 16'h0000;
  logic [7:0] code;
  logic [3:0] state;
  ebs_times_t times = {16'h0002, 16'h0002, 16'h0002, 16'h0005};
  ebs_drive_out_t dout;
  int err_count = 0;
  int check_count = 0;
  int n;
  ebs_row_t rows [3] = '{'{1'b1, 2'h0, EBS_RUN, 10'h200},
    '{1'b0, 2'h0, EBS_FAULT, 10'h100}, '{1'b1, 2'h1, EBS_FAULT, 10'h120}};
  ebs_sequencer #(.MS_CYCLES(2)) u_ebs_sequencer (
    .clock_in(clk), .rst_b_in(rst_b), .brake_control_enable_in(en),
    .times_in(times), .brake_enable_frequency_in(FB),
    .setpoint_frequency_in(FS), .drive_in({st, sp, at, cur}),
    .drive_out(dout), .brake_confirm_input_in(conf), .fault_clear_in(clr),
    .brake_release_output_out(rel), .brake_fault_output_out(flt),
    .fault_code_out(code), .state_out(state));
  ebs_brake_model u_ebs_brake_model (.clock_in(clk), .rst_b_in(rst_b),
    .release_in(rel), .mode_in(mode), .confirm_out(conf));
  // drive reports arrival one cycle after target settles
  always @(negedge clk) begin
    at <= dout.ramp_enable && dout.freq_target === tgt_q;
    tgt_q <= dout.freq_target;
  end
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic wait_st(logic [3:0] s);
    for (int n = 0; n < 300 && state !== s; n++) @(negedge clk);
    chk("state", state, s);
    if (state !== s) close_out();
  endtask
  initial begin
    repeat (12) @(negedge clk);
    chk("reset", {rel, flt, code, state, dout}, 32'h0);
    rst_b = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      cur = rows[i].cur;
      mode = rows[i].mode;
      pulse(st);
      wait_st(rows[i].st);
      chk("outs", {rel, flt, code}, rows[i].outs);
      if (state === EBS_RUN) begin
        chk("setpoint", dout.freq_target, FS);
        pulse(sp);
        wait_st(EBS_ENG_WAIT);
        chk("engage", {rel, dout.freq_target}, FB);
        wait_st(EBS_TO_ZERO);
        chk("zero", dout.freq_target, 16'h0000);
        wait_st(EBS_IDLE);
      end else begin
        pulse(st);
        chk("hold", {flt, state}, {1'b1, EBS_FAULT});
        pulse(clr);
        wait_st(EBS_IDLE);
      end
      $display("test %0d done", i);
    end
    mode = 2'h2;
    pulse(st);
    wait_st(EBS_RUN);
    pulse(sp);
    wait_st(EBS_FAULT);
    chk("stop fault", {flt, code}, 9'h124);
    mode = 2'h0;
    pulse(clr);
    wait_st(EBS_IDLE);
    $display("test stuck brake done");
    // oversized release wait must clamp to 5000 ms of 2 cycles each
    times.release_wait_time = 16'hFFFF;
    pulse(st);
    wait_st(EBS_REL_WAIT);
    n = 0;
    while (state === EBS_REL_WAIT && n < 12000) begin
      n++;
      @(negedge clk);
    end
    chk("clamp", 32'(n >= 10000 && n <= 10002), 32'h1);
    times.release_wait_time = 16'h0002;
    wait_st(EBS_RUN);
    $display("test clamp done");
    en = 2'h0;
    repeat (2) @(negedge clk);
    chk("abort", {state, rel, dout.ramp_enable}, 32'h0);
    en = 2'h2;
    pulse(st);
    repeat (20) @(negedge clk);
    chk("disabled", {state, rel, dout.ramp_enable}, 32'h0);
    $display("test disabled done");
    en = 2'h1;
    pulse(st);
    wait_st(EBS_RUN);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk("mid reset", {rel, flt, code, state, dout}, 32'h0);
    rst_b = 1'b1;
    pulse(st);
    wait_st(EBS_RAMP_UP);
    $display("test mid reset done");
    close_out();
  end
endmodule
`default_nettype wire
